// File: rtl/pclm_top.sv
// front-panel status led multiplexer: red failure flags, green code display
// assumes all inputs synchronous to CLK; led outputs are active high (lit = 1)
`timescale 1ns/100ps
module pclm_top #(
    parameter logic [31:0] HOLD_CYCLES = 32'(pclm_pkg::PCLM_HOLD_CYC)
) (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [3:0] BOARD_CONFIG_SWITCH,
    input  wire logic       FW_STARTED,
    input  wire logic       BOOT_DONE,
    input  wire logic       FAIL_POWER,
    input  wire logic       FAIL_CPU_CATERR,
    input  wire logic       FAIL_HW_RESET,
    input  wire logic       FAIL_FW_BOOT,
    input  wire logic [7:0] POST_CODE,
    input  wire logic       POST_CODE_WE,
    input  wire logic [7:0] DEBUG_PORT_CODE,
    input  wire logic       DEBUG_PORT_WE,
    input  wire logic [3:0] GP_VALUE,
    input  wire logic       GP_WE,
    input  wire logic       SRC_SEL,
    input  wire logic       SRC_SEL_WE,
    output logic      [3:0] STATUS_LED_GROUP_RED,
    output logic      [3:0] STATUS_LED_GROUP_GREEN,
    output logic      [1:0] PHASE
);
    logic [7:0] post_code_reg;
    logic [7:0] dbg_code_reg;
    logic [3:0] gp_reg;
    logic       sel_reg;
    logic [3:0] fail_reg;
    logic       post_en_reg;
    pclm_pkg::pclm_phase_e phase_reg;
    pclm_pkg::pclm_phase_e phase_next;
    logic [3:0] red_next;
    logic [3:0] green_next;
    logic [3:0] mux_leds;
    logic [7:0] mux_code;
    logic       mux_run;
    logic       tick;
    logic       status_led_three;
    logic       status_led_two;
    logic       status_led_one;
    logic       status_led_zero;

    // boot phase advances only forward; reset returns to early boot
    assign phase_next = BOOT_DONE  ? pclm_pkg::PCLM_PH_APP  :
                        FW_STARTED ? pclm_pkg::PCLM_PH_POST :
                                     pclm_pkg::PCLM_PH_EARLY;

    // failure flags are latched only before firmware runs, so late events never show red
    assign status_led_three = fail_reg[3] | (FAIL_POWER      && phase_reg == pclm_pkg::PCLM_PH_EARLY);
    assign status_led_two   = fail_reg[2] | (FAIL_CPU_CATERR && phase_reg == pclm_pkg::PCLM_PH_EARLY);
    assign status_led_one   = fail_reg[1] | (FAIL_HW_RESET   && phase_reg == pclm_pkg::PCLM_PH_EARLY);
    assign status_led_zero  = fail_reg[0] | (FAIL_FW_BOOT    && phase_reg == pclm_pkg::PCLM_PH_EARLY);

    // the multiplexer runs for code display in post phase, or debug code after boot
    assign mux_code = (phase_reg == pclm_pkg::PCLM_PH_APP) ? dbg_code_reg : post_code_reg;
    assign mux_run  = ((phase_reg == pclm_pkg::PCLM_PH_POST) && post_en_reg) ||
                      ((phase_reg == pclm_pkg::PCLM_PH_APP) && sel_reg == pclm_pkg::PCLM_SEL_DBG);

    // red shows failures only while firmware has not started
    assign red_next = (phase_reg == pclm_pkg::PCLM_PH_EARLY) ?
        {status_led_three, status_led_two, status_led_one, status_led_zero} :
        pclm_pkg::PCLM_LEDS_OFF;

    // green source per phase; disabled code display leaves green dark
    assign green_next =
        (phase_reg == pclm_pkg::PCLM_PH_APP) ?
            ((sel_reg == pclm_pkg::PCLM_SEL_GP) ? gp_reg : mux_leds) :
        (phase_reg == pclm_pkg::PCLM_PH_POST && post_en_reg) ? mux_leds :
        pclm_pkg::PCLM_LEDS_OFF;

    pclm_timer u_timer (
        .clk         (CLK),
        .rst_n       (RST_N),
        .run         (mux_run),
        .hold_cycles (HOLD_CYCLES),
        .tick        (tick)
    );

    pclm_seq u_seq (
        .clk   (CLK),
        .rst_n (RST_N),
        .run   (mux_run),
        .tick  (tick),
        .code  (mux_code),
        .leds  (mux_leds)
    );

    // firmware written values and selection
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            post_code_reg <= pclm_pkg::PCLM_CODE_RST;
            dbg_code_reg  <= pclm_pkg::PCLM_CODE_RST;
            gp_reg        <= pclm_pkg::PCLM_LEDS_OFF;
            sel_reg       <= pclm_pkg::PCLM_SEL_GP;
        end else begin
            if (POST_CODE_WE)  post_code_reg <= POST_CODE;
            if (DEBUG_PORT_WE) dbg_code_reg  <= DEBUG_PORT_CODE;
            if (GP_WE)         gp_reg        <= GP_VALUE;
            if (SRC_SEL_WE)    sel_reg       <= SRC_SEL;
        end
    end

    // phase, sticky early failures and the switch setting
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_reg   <= pclm_pkg::PCLM_PH_EARLY;
            fail_reg    <= pclm_pkg::PCLM_LEDS_OFF;
            post_en_reg <= 1'b0;
        end else begin
            if (phase_next > phase_reg) phase_reg <= phase_next;
            fail_reg    <= {status_led_three, status_led_two, status_led_one, status_led_zero};
            post_en_reg <= BOARD_CONFIG_SWITCH[pclm_pkg::PCLM_SW_POST];
        end
    end

    // all outputs registered
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            STATUS_LED_GROUP_RED   <= pclm_pkg::PCLM_LEDS_OFF;
            STATUS_LED_GROUP_GREEN <= pclm_pkg::PCLM_LEDS_OFF;
            PHASE                  <= pclm_pkg::PCLM_PH_EARLY;
        end else begin
            STATUS_LED_GROUP_RED   <= red_next;
            STATUS_LED_GROUP_GREEN <= green_next;
            PHASE                  <= phase_reg;
        end
    end
endmodule

// File: common/pclm_pkg.sv
// constants and types for the post code led multiplexer
// assumes a single 100 MHz clock domain and no register bus
// Notes on behaviour
// - show boot code first, then application use
// - after boot, general purpose or debug-port code
// - reset default selects general purpose values
// - red elements flag early failures per led
// - red marks failures before firmware runs
// - led n shows code bits n+4, n
// - multiplex eight-bit code one nibble at time
// - state zero blanks all leds first
// - states cycle zero, high, low, zero
// - debug-port code uses same bit mapping
// - switch position zero enables code display
package pclm_pkg;
    localparam int          PCLM_LED_W    = 4;
    localparam int          PCLM_CODE_W   = 8;
    localparam int          PCLM_HOLD_W   = 32;
    // half a second per state is easily readable by eye
    localparam int          PCLM_HOLD_MS  = 500;
    localparam int          PCLM_CLK_MHZ  = 100;
    localparam int          PCLM_HOLD_CYC = PCLM_HOLD_MS * 1000 * PCLM_CLK_MHZ;
    localparam logic [3:0]  PCLM_LEDS_OFF = 4'h0;
    localparam logic [7:0]  PCLM_CODE_RST = 8'h00;
    localparam int          PCLM_SW_POST  = 0;
    localparam logic        PCLM_SEL_GP   = 1'b0;
    localparam logic        PCLM_SEL_DBG  = 1'b1;

    typedef enum logic [1:0] {
        PCLM_ST_BLANK = 2'b00,
        PCLM_ST_HIGH  = 2'b01,
        PCLM_ST_LOW   = 2'b10
    } pclm_state_e;

    typedef enum logic [1:0] {
        PCLM_PH_EARLY = 2'b00,
        PCLM_PH_POST  = 2'b01,
        PCLM_PH_APP   = 2'b10
    } pclm_phase_e;

    // nibble of a code for one multiplex state; the high state reads as the upper hex digit
    function automatic logic [3:0] pclm_nibble(input logic [7:0] code, input logic hi);
        pclm_nibble = hi ? code[7:4] : code[3:0];
    endfunction
endpackage

// File: rtl/pclm_timer.sv
// hold timer: pulses once every hold_cycles clocks
// assumes hold_cycles is at least one
`timescale 1ns/100ps
module pclm_timer (
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    input  wire logic                           run,
    input  wire logic [pclm_pkg::PCLM_HOLD_W-1:0] hold_cycles,
    output logic                                tick
);
    logic [pclm_pkg::PCLM_HOLD_W-1:0] cnt_reg;
    logic [pclm_pkg::PCLM_HOLD_W-1:0] cnt_next;
    logic                             done;

    // count restarts whenever the multiplexer is idle so a new sequence is aligned
    assign done     = (cnt_reg + 32'h1 >= hold_cycles);
    assign cnt_next = (!run || done) ? 32'h0 : cnt_reg + 32'h1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 32'h0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick    <= run && done;
        end
    end
endmodule

// File: rtl/pclm_seq.sv
// three-state nibble sequencer for an 8-bit code
// assumes tick is a one-cycle pulse from the hold timer
`timescale 1ns/100ps
module pclm_seq (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       run,
    input  wire logic                       tick,
    input  wire logic [7:0]                 code,
    output logic      [3:0]                 leds
);
    pclm_pkg::pclm_state_e state_reg;
    pclm_pkg::pclm_state_e state_next;

    // blank, high, low, then back to blank
    always_comb begin
        state_next = state_reg;
        if (!run) begin
            state_next = pclm_pkg::PCLM_ST_BLANK;
        end else if (tick) begin
            case (state_reg)
                pclm_pkg::PCLM_ST_BLANK: state_next = pclm_pkg::PCLM_ST_HIGH;
                pclm_pkg::PCLM_ST_HIGH:  state_next = pclm_pkg::PCLM_ST_LOW;
                pclm_pkg::PCLM_ST_LOW:   state_next = pclm_pkg::PCLM_ST_BLANK;
                default:                 state_next = pclm_pkg::PCLM_ST_BLANK;
            endcase
        end
    end

    // led n carries bit n+4 in the high phase and bit n in the low phase
    always_comb begin
        case (state_reg)
            pclm_pkg::PCLM_ST_HIGH: leds = pclm_pkg::pclm_nibble(code, 1'b1);
            pclm_pkg::PCLM_ST_LOW:  leds = pclm_pkg::pclm_nibble(code, 1'b0);
            default:                leds = pclm_pkg::PCLM_LEDS_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pclm_pkg::PCLM_ST_BLANK;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule

// File: tb/pclm_assertions.sv
// checker for the status led multiplexer, bound to pclm_top
// assumes the post code input holds steady between writes
`timescale 1ns/100ps
module pclm_assertions #(
    parameter logic [31:0] HOLD_CYCLES = 32'h4
) (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [3:0] BOARD_CONFIG_SWITCH,
    input wire logic       FW_STARTED,
    input wire logic       FAIL_POWER,
    input wire logic [7:0] POST_CODE,
    input wire logic [3:0] STATUS_LED_GROUP_RED,
    input wire logic [3:0] STATUS_LED_GROUP_GREEN,
    input wire logic [1:0] PHASE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [3:0]  grn_reg;
    logic [31:0] run_reg;
    logic        full_reg;
    wire  [3:0]  g = STATUS_LED_GROUP_GREEN;
    wire  [3:0]  lo = POST_CODE[3:0];
    wire  [3:0]  hi = POST_CODE[7:4];
    wire         chg = g != grn_reg;
    // distinct non-zero nibbles, else runs merge and cannot be judged
    wire         live = PHASE == 2'h1 && BOARD_CONFIG_SWITCH[0] && lo != 4'h0 && hi != 4'h0
                        && lo != hi;
    // run length of the green pattern; the first run after entry is partial
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            grn_reg <= 4'h0;
            run_reg <= 32'h0;
            full_reg <= 1'b0;
        end else begin
            grn_reg <= g;
            run_reg <= chg ? 32'h0 : run_reg + 32'h1;
            full_reg <= live && (full_reg || chg);
        end
    end
    sequence s_steady;
        (live && $stable(POST_CODE)) [*8];
    endsequence
    a_reset_dark: assert property (disable iff (1'b0) $rose(RST_N) |->
        STATUS_LED_GROUP_RED == 4'h0 && g == 4'h0 && PHASE == 2'h0) else $error("dark reset");
    a_red_cause: assert property ($rose(STATUS_LED_GROUP_RED[3]) |-> $past(FAIL_POWER))
        else $error("red without failure");
    a_red_leave: assert property (PHASE != 2'h0 |=> STATUS_LED_GROUP_RED == 4'h0)
        else $error("red after firmware");
    a_phase_move: assert property (PHASE == 2'h0 && FW_STARTED |-> ##[1:2] PHASE == 2'h1)
        else $error("phase stuck");
    a_green_gated: assert property ((PHASE == 2'h1 && !BOARD_CONFIG_SWITCH[0]) [*3] |->
        g == 4'h0) else $error("green while disabled");
    // run_reg holds one less than the run length at the change that ends it
    a_hold_len: assert property (chg && full_reg && live |-> run_reg == HOLD_CYCLES - 32'h1)
        else $error("state hold length");
    a_blank_high: assert property (s_steady ##0 ($past(g) == 4'h0 && g != 4'h0) |-> g == hi)
        else $error("blank not followed by high");
    a_high_low: assert property (s_steady ##0 ($past(g) == hi && g != hi) |-> g == lo)
        else $error("high not followed by low");
    a_low_blank: assert property (s_steady ##0 ($past(g) == lo && g != lo) |-> g == 4'h0)
        else $error("low not followed by blank");
endmodule
bind pclm_top pclm_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) i_pclm_assertions (.CLK, .RST_N,
    .BOARD_CONFIG_SWITCH, .FW_STARTED, .FAIL_POWER, .POST_CODE, .STATUS_LED_GROUP_RED,
    .STATUS_LED_GROUP_GREEN, .PHASE);

// File: tb/pclm_panel.sv
// front panel model: reads the green elements as an eye would
// assumes lit = 1; reports each finished run of one pattern
`timescale 1ns/100ps
module pclm_panel (
    input  wire logic        clk,
    input  wire logic [3:0]  green,
    output logic      [3:0]  run_val,
    output logic      [31:0] run_len,
    output logic             run_done
);
    logic [3:0]  cur_reg;
    logic [31:0] len_reg;
    // a pattern is only read once it has been replaced
    always_ff @(posedge clk) begin
        run_done <= green != cur_reg;
        if (green != cur_reg) begin
            run_val <= cur_reg;
            run_len <= len_reg;
            len_reg <= 32'h1;
        end else begin
            len_reg <= len_reg + 32'h1;
        end
        cur_reg <= green;
    end
endmodule

// File: tb/pclm_top_tb.sv
// self-checking bench for pclm_top with a short hold count
// assumes inputs driven at the falling edge, outputs read there too
`timescale 1ns/100ps
module pclm_top_tb;
    localparam int H = 4;
    logic        clk = 0, rst_n = 0, fw = 0, done = 0, pwe = 0, dwe = 0, gwe = 0, sel = 0;
    logic        swe = 0, rd;
    logic [3:0]  sw = 0, fail = 0, gp = 0, red, green, rv;
    logic [7:0]  code = 0, dbg = 0;
    logic [1:0]  phase;
    logic [31:0] rl, seed = 32'd88460;
    int          errors = 0, total_checks = 0;
    always #5 clk = ~clk;
    pclm_top #(.HOLD_CYCLES(32'(H))) i_pclm_top (.CLK(clk), .RST_N(rst_n),
        .BOARD_CONFIG_SWITCH(sw), .FW_STARTED(fw), .BOOT_DONE(done), .FAIL_POWER(fail[3]),
        .FAIL_CPU_CATERR(fail[2]), .FAIL_HW_RESET(fail[1]), .FAIL_FW_BOOT(fail[0]),
        .POST_CODE(code), .POST_CODE_WE(pwe), .DEBUG_PORT_CODE(dbg), .DEBUG_PORT_WE(dwe),
        .GP_VALUE(gp), .GP_WE(gwe), .SRC_SEL(sel), .SRC_SEL_WE(swe),
        .STATUS_LED_GROUP_RED(red), .STATUS_LED_GROUP_GREEN(green), .PHASE(phase));
    pclm_panel i_pclm_panel (.clk(clk), .green(green), .run_val(rv), .run_len(rl),
        .run_done(rd));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // xorshift keeps the run repeatable from its fixed start
    function automatic logic [31:0] rnd(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        rnd = x ^ (x << 5);
    endfunction
    task automatic wait_phase(input logic [1:0] p);
        for (int n = 0; n < 20 && phase !== p; n++) cyc(1);
        chk("phase", {6'h0, phase}, {6'h0, p});
        if (phase !== p) tally_and_finish();
    endtask
    // model of the multiplex: blank, bits n+4, bits n, each held H clocks
    task automatic watch(input logic [7:0] c);
        logic [3:0] e[3];
        int k;
        e = '{4'h0, c[7:4], c[3:0]};
        k = -1;
        repeat (70) begin
            cyc(1);
            if (rd === 1'b1 && k >= 0) begin
                k++;
                chk("run value", {4'h0, rv}, {4'h0, e[k % 3]});
                chk("run length", rl[7:0], 8'(H));
            end else if (rd === 1'b1 && rv === 4'h0) k = 0;
        end
        chk("runs seen", 8'(k > 6), 8'h1);
    endtask
    initial begin
        cyc(10);
        rst_n = 1;
        cyc(1);
        chk("red reset", {4'h0, red}, 8'h0);
        seed = rnd(seed);
        // power failure always raised so its red element is seen to rise
        fail = {1'b1, seed[2:0]};
        cyc(3);
        fail = 0;
        cyc(2);
        chk("red flags", {4'h0, red}, {5'h01, seed[2:0]});
        chk("green early", {4'h0, green}, 8'h0);
        fw = 1;
        wait_phase(2'h1);
        fail = 4'hF;
        cyc(3);
        chk("red post", {4'h0, red}, 8'h0);
        for (int j = 0; j < 2; j++) begin
            seed = rnd(seed);
            code = {1'b1, seed[6:5], 1'b0, seed[3:1], 1'b1};
            sw = {seed[11:9], 1'b0};
            pwe = 1;
            cyc(1);
            pwe = 0;
            cyc(12);
            chk("green disabled", {4'h0, green}, 8'h0);
            sw[0] = 1;
            watch(code);
            sw[0] = 0;
            cyc(3);
        end
        done = 1;
        wait_phase(2'h2);
        seed = rnd(seed);
        gp = seed[3:0];
        dbg = {1'b1, seed[6:5], 1'b0, seed[10:8], 1'b1};
        gwe = 1;
        dwe = 1;
        cyc(1);
        gwe = 0;
        dwe = 0;
        cyc(3);
        chk("gp default", {4'h0, green}, {4'h0, gp});
        sel = 1;
        swe = 1;
        cyc(1);
        swe = 0;
        watch(dbg);
        sel = 0;
        swe = 1;
        cyc(1);
        swe = 0;
        cyc(3);
        chk("gp again", {4'h0, green}, {4'h0, gp});
        tally_and_finish();
    end
endmodule
